// >>> hdl/tmc_pkg.sv
// package: register map, field layout and types for the timer mode control block
package tmc_pkg;

  // register byte offsets
  localparam logic [7:0] TMC_OFS_SYNC_SEL  = 8'h61;
  localparam logic [7:0] TMC_OFS_MODE_SEL  = 8'h62;
  localparam logic [7:0] TMC_OFS_COMBO_SEL = 8'h71;
  localparam logic [7:0] TMC_OFS_IRQ_STAT  = 8'h72;
  localparam logic [7:0] TMC_OFS_IRQ_MASK  = 8'h73;

  // reset values
  localparam logic [7:0] TMC_RST_MODE_SEL  = 8'h80;
  localparam logic [4:0] TMC_RST_SYNC      = 5'h00;
  localparam logic [1:0] TMC_RST_COMBO     = 2'h0;
  localparam logic [1:0] TMC_RST_IRQ_MASK  = 2'h0;
  localparam logic [7:0] TMC_RD_ZERO       = 8'h00;

  // timer_mode_select field layout
  localparam int unsigned TMC_BIT_PWM_LO   = 0;
  localparam int unsigned TMC_BIT_PWM_HI   = 4;
  localparam int unsigned TMC_BIT_FLAG_DIRECTION_SELECT     = 5;
  localparam int unsigned TMC_BIT_PCM      = 6;
  localparam int unsigned TMC_BIT_MODE_RSV = 7;

  // sync select layout: one bit per channel, channel 4 at bit 4
  localparam int unsigned TMC_BIT_SYNC_LO  = 0;
  localparam int unsigned TMC_BIT_SYNC_HI  = 4;
  localparam int unsigned TMC_BIT_SYNC_CH4 = 4;

  // combination select layout
  localparam int unsigned TMC_BIT_CMD_LO   = 4;
  localparam int unsigned TMC_BIT_CMD_HI   = 5;

  // interrupt status / mask layout
  localparam int unsigned TMC_NUM_EVT      = 2;
  localparam int unsigned TMC_EVT_OVF      = 0;
  localparam int unsigned TMC_EVT_UDF      = 1;

  // joint operating mode of channels 3 and 4
  typedef enum logic [1:0] {
    TMC_PAIR_INDEPENDENT,
    TMC_PAIR_COMPLEMENTARY,
    TMC_PAIR_RESET_SYNC
  } tmc_pair_mode_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmc_bus_req_t;

  // decoded channel controls toward the counters
  typedef struct packed {
    logic [4:0]     pwm_mode;
    logic           ch2_phase_count;
    logic           ch2_ovf_on_udf;
    tmc_pair_mode_t pair_mode;
    logic [4:0]     sync_sel;
  } tmc_mode_t;

  // counter events from channel 2
  typedef struct packed {
    logic ovf;
    logic udf;
  } tmc_cnt_evt_t;

endpackage

// >>> hdl/tmc_event_flag.sv
// sticky event flag: hardware sets, software clears, set wins
`timescale 1ns/100ps
module tmc_event_flag (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);

  logic flag_reg;

  // a set in the clear cycle survives, so no event is lost on read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= 1'b0;
    end else if (i_set) begin
      flag_reg <= 1'b1;
    end else if (i_clr) begin
      flag_reg <= 1'b0;
    end
  end

  assign o_flag = flag_reg;

endmodule // tmc_event_flag

// >>> hdl/tmc_mode_ctrl.sv
// timer mode control: mode registers, channel mode decode, channel 2 flag events
// software writes byte registers over a one-cycle strobe port; reads return
// registered data in the following cycle only. decoded controls leave as flops,
// one cycle behind the register they come from, so a counter never sees a
// half-written mode. channel 2 events land in sticky status bits that a status
// read clears; a set in the clearing cycle wins.
`timescale 1ns/100ps
module tmc_mode_ctrl
  import tmc_pkg::*;
(
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  input  wire tmc_bus_req_t  i_bus,
  input  wire tmc_cnt_evt_t  i_cnt2_evt,
  output logic [7:0]         o_rdata,
  output tmc_mode_t          o_mode,
  output logic               o_ovf_ch2,
  output logic               o_irq
);

  // software-visible state
  logic [4:0]                pwm_reg;
  logic                      flag_direction_select_reg;
  logic                      pcm_reg;
  logic [4:0]                sync_reg;
  logic [1:0]                combo_reg;
  logic [TMC_NUM_EVT-1:0]    mask_reg;
  logic [TMC_NUM_EVT-1:0]    stat_flag;

  // output and read path registers
  logic [7:0]                rdata_reg;
  tmc_mode_t                 mode_next;
  logic [4:0]                pwm_out_reg;
  logic                      pcm_out_reg;
  logic                      udf_out_reg;
  tmc_pair_mode_t            pair_out_reg;
  logic [4:0]                sync_out_reg;
  logic                      ovf_reg;
  logic                      irq_reg;

  // bus decode
  logic                      wr_mode;
  logic                      wr_sync;
  logic                      wr_combo;
  logic                      wr_mask;
  logic                      rd_stat;
  logic [7:0]                rdata_next;

  // per-register read images
  logic [7:0]                mode_img;
  logic [7:0]                sync_img;
  logic [7:0]                combo_img;
  logic [7:0]                stat_img;
  logic [7:0]                mask_img;

  // event terms
  logic                      ovf_set;
  logic                      udf_set;
  logic [TMC_NUM_EVT-1:0]    evt_set;

  // address decode; strobes never overlap so each write hits at most one register
  always_comb begin
    wr_mode  = i_bus.wr && (i_bus.addr == TMC_OFS_MODE_SEL);
    wr_sync  = i_bus.wr && (i_bus.addr == TMC_OFS_SYNC_SEL);
    wr_combo = i_bus.wr && (i_bus.addr == TMC_OFS_COMBO_SEL);
    wr_mask  = i_bus.wr && (i_bus.addr == TMC_OFS_IRQ_MASK);
    rd_stat  = i_bus.rd && (i_bus.addr == TMC_OFS_IRQ_STAT);
  end

  // per-channel PWM select bits
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_reg <= TMC_RST_MODE_SEL[TMC_BIT_PWM_HI:TMC_BIT_PWM_LO];
    end else if (wr_mode) begin
      pwm_reg <= i_bus.wdata[TMC_BIT_PWM_HI:TMC_BIT_PWM_LO];
    end
  end

  // channel 2 flag direction select
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_direction_select_reg <= TMC_RST_MODE_SEL[TMC_BIT_FLAG_DIRECTION_SELECT];
    end else if (wr_mode) begin
      flag_direction_select_reg <= i_bus.wdata[TMC_BIT_FLAG_DIRECTION_SELECT];
    end
  end

  // channel 2 phase counting select
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pcm_reg <= TMC_RST_MODE_SEL[TMC_BIT_PCM];
    end else if (wr_mode) begin
      pcm_reg <= i_bus.wdata[TMC_BIT_PCM];
    end
  end

  // counter synchronization selects, one per channel
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= TMC_RST_SYNC;
    end else if (wr_sync) begin
      sync_reg <= i_bus.wdata[TMC_BIT_SYNC_HI:TMC_BIT_SYNC_LO];
    end
  end

  // combination mode field for channels 3 and 4
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      combo_reg <= TMC_RST_COMBO;
    end else if (wr_combo) begin
      combo_reg <= i_bus.wdata[TMC_BIT_CMD_HI:TMC_BIT_CMD_LO];
    end
  end

  // interrupt mask, same layout as the status register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_reg <= TMC_RST_IRQ_MASK;
    end else if (wr_mask) begin
      mask_reg <= i_bus.wdata[TMC_NUM_EVT-1:0];
    end
  end

  // decode of the mode registers into per-channel controls
  always_comb begin
    mode_next                 = '0;
    mode_next.pwm_mode        = pwm_reg;
    mode_next.ch2_phase_count = pcm_reg;
    mode_next.ch2_ovf_on_udf  = ~flag_direction_select_reg;
    mode_next.sync_sel        = sync_reg;
    // channel 4 runs free unless its own select is set
    mode_next.sync_sel[TMC_BIT_SYNC_CH4] = sync_reg[TMC_BIT_SYNC_CH4];
    case (combo_reg)
      2'b00:   mode_next.pair_mode = TMC_PAIR_INDEPENDENT;
      2'b01:   mode_next.pair_mode = TMC_PAIR_INDEPENDENT;
      2'b10:   mode_next.pair_mode = TMC_PAIR_COMPLEMENTARY;
      2'b11:   mode_next.pair_mode = TMC_PAIR_RESET_SYNC;
      default: mode_next.pair_mode = TMC_PAIR_INDEPENDENT;
    endcase
  end

  // pwm selects toward the counters; one cycle behind the register write
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_out_reg <= '0;
    end else begin
      pwm_out_reg <= mode_next.pwm_mode;
    end
  end

  // channel 2 phase counting control
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pcm_out_reg <= 1'b0;
    end else begin
      pcm_out_reg <= mode_next.ch2_phase_count;
    end
  end

  // channel 2 underflow-sets-flag control; zero in reset and while the flag direction bit is set
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      udf_out_reg <= 1'b0;
    end else begin
      udf_out_reg <= mode_next.ch2_ovf_on_udf;
    end
  end

  // joint mode of channels 3 and 4
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pair_out_reg <= TMC_PAIR_INDEPENDENT;
    end else begin
      pair_out_reg <= mode_next.pair_mode;
    end
  end

  // counter synchronization controls
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_out_reg <= '0;
    end else begin
      sync_out_reg <= mode_next.sync_sel;
    end
  end

  // channel 2 events; underflow sets the overflow bit only when the direction bit allows it
  always_comb begin
    ovf_set = i_cnt2_evt.ovf || (i_cnt2_evt.udf && !flag_direction_select_reg);
    udf_set = i_cnt2_evt.udf;
    evt_set = '0;
    evt_set[TMC_EVT_OVF] = ovf_set;
    evt_set[TMC_EVT_UDF] = udf_set;
  end

  // sticky status bits, cleared by a read of the status register
  for (genvar g = 0; g < TMC_NUM_EVT; g++) begin : g_evt
    tmc_event_flag u_flag (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_set     (evt_set[g]),
      .i_clr     (rd_stat),
      .o_flag    (stat_flag[g])
    );
  end

  // overflow flag mirrored toward the channel 2 status logic
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= stat_flag[TMC_EVT_OVF];
    end
  end

  // level interrupt while any unmasked status bit stands
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_flag & mask_reg);
    end
  end

  // mode register image; the reserved top bit always reads as set
  always_comb begin
    mode_img                                = TMC_RD_ZERO;
    mode_img[TMC_BIT_MODE_RSV]              = TMC_RST_MODE_SEL[TMC_BIT_MODE_RSV];
    mode_img[TMC_BIT_PCM]                   = pcm_reg;
    mode_img[TMC_BIT_FLAG_DIRECTION_SELECT]                  = flag_direction_select_reg;
    mode_img[TMC_BIT_PWM_HI:TMC_BIT_PWM_LO] = pwm_reg;
  end

  // sync select image
  always_comb begin
    sync_img                                  = TMC_RD_ZERO;
    sync_img[TMC_BIT_SYNC_HI:TMC_BIT_SYNC_LO] = sync_reg;
  end

  // combination field image
  always_comb begin
    combo_img                                = TMC_RD_ZERO;
    combo_img[TMC_BIT_CMD_HI:TMC_BIT_CMD_LO] = combo_reg;
  end

  // status image; the read that returns it also clears it
  always_comb begin
    stat_img                  = TMC_RD_ZERO;
    stat_img[TMC_NUM_EVT-1:0] = stat_flag;
  end

  // mask image
  always_comb begin
    mask_img                  = TMC_RD_ZERO;
    mask_img[TMC_NUM_EVT-1:0] = mask_reg;
  end

  // read mux; unmapped addresses and idle cycles read zero
  always_comb begin
    rdata_next = TMC_RD_ZERO;
    if (i_bus.rd) begin
      case (i_bus.addr)
        TMC_OFS_MODE_SEL: begin
          rdata_next = mode_img;
        end
        TMC_OFS_SYNC_SEL: begin
          rdata_next = sync_img;
        end
        TMC_OFS_COMBO_SEL: begin
          rdata_next = combo_img;
        end
        TMC_OFS_IRQ_STAT: begin
          rdata_next = stat_img;
        end
        TMC_OFS_IRQ_MASK: begin
          rdata_next = mask_img;
        end
        default: begin
          rdata_next = TMC_RD_ZERO;
        end
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= TMC_RD_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata   = rdata_reg;
  assign o_mode    = '{pwm_mode:        pwm_out_reg,
                       ch2_phase_count: pcm_out_reg,
                       ch2_ovf_on_udf:  udf_out_reg,
                       pair_mode:       pair_out_reg,
                       sync_sel:        sync_out_reg};
  assign o_ovf_ch2 = ovf_reg;
  assign o_irq     = irq_reg;

endmodule // tmc_mode_ctrl

// >>> tb/tmc_mode_ctrl_assertions.sv
// checker: decode and timing properties at the mode control ports
`timescale 1ns/100ps
module tmc_mode_ctrl_assertions
  import tmc_pkg::*;
(
  input wire logic         i_clk_sys,
  input wire logic         i_rst_n,
  input wire tmc_bus_req_t i_bus,
  input wire tmc_cnt_evt_t i_cnt2_evt,
  input wire logic [7:0]   o_rdata,
  input wire tmc_mode_t    o_mode,
  input wire logic         o_ovf_ch2,
  input wire logic         o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // writes land in the outputs two edges later
  sequence s_wr_mode;
    i_bus.wr && i_bus.addr == TMC_OFS_MODE_SEL;
  endsequence
  sequence s_wr_combo;
    i_bus.wr && i_bus.addr == TMC_OFS_COMBO_SEL;
  endsequence
  sequence s_wr_sync;
    i_bus.wr && i_bus.addr == TMC_OFS_SYNC_SEL;
  endsequence
  property p_pwm;
    s_wr_mode |-> ##2 o_mode.pwm_mode == $past(i_bus.wdata[4:0], 2);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm select wrong");
  property p_pcm;
    s_wr_mode |-> ##2 o_mode.ch2_phase_count == $past(i_bus.wdata[6], 2);
  endproperty
  a_pcm: assert property (p_pcm) else $error("phase count wrong");
  property p_flag_direction_select;
    s_wr_mode |-> ##2 o_mode.ch2_ovf_on_udf != $past(i_bus.wdata[5], 2);
  endproperty
  a_flag_direction_select: assert property (p_flag_direction_select) else $error("flag direction wrong");
  property p_pair;
    s_wr_combo |-> ##2 o_mode.pair_mode == (!$past(i_bus.wdata[5], 2) ? TMC_PAIR_INDEPENDENT
      : $past(i_bus.wdata[4], 2) ? TMC_PAIR_RESET_SYNC : TMC_PAIR_COMPLEMENTARY);
  endproperty
  a_pair: assert property (p_pair) else $error("pair mode wrong");
  property p_sync;
    s_wr_sync |-> ##2 o_mode.sync_sel[TMC_BIT_SYNC_CH4]
      == $past(i_bus.wdata[TMC_BIT_SYNC_CH4], 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync select wrong");
  // stale o_mode right after a write, so skip that case
  property p_udf;
    i_cnt2_evt.udf && o_mode.ch2_ovf_on_udf && !$past(i_bus.wr) |-> ##2 o_ovf_ch2;
  endproperty
  a_udf: assert property (p_udf) else $error("underflow flag missing");
  property p_ovf;
    i_cnt2_evt.ovf |-> ##2 o_ovf_ch2;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag missing");
  property p_rd_idle;
    !i_bus.rd |=> o_rdata == TMC_RD_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_rsv;
    i_bus.rd && i_bus.addr == TMC_OFS_MODE_SEL |=> o_rdata[7];
  endproperty
  a_rd_rsv: assert property (p_rd_rsv) else $error("reserved bit not 1");
endmodule // tmc_mode_ctrl_assertions

bind tmc_mode_ctrl tmc_mode_ctrl_assertions i_chk (
  .i_clk_sys (i_clk_sys),
  .i_rst_n   (i_rst_n),
  .i_bus     (i_bus),
  .i_cnt2_evt(i_cnt2_evt),
  .o_rdata   (o_rdata),
  .o_mode    (o_mode),
  .o_ovf_ch2 (o_ovf_ch2),
  .o_irq     (o_irq)
);

// >>> tb/tmc_mode_ctrl_tb_top.sv
// testbench: register bus and event tests of the mode control block
`timescale 1ns/100ps
module tmc_mode_ctrl_tb_top
  import tmc_pkg::*;
;
  logic         i_clk_sys = 1'b0;
  logic         i_rst_n = 1'b0;
  tmc_bus_req_t i_bus = '0;
  tmc_cnt_evt_t i_cnt2_evt = '0;
  logic [7:0]   o_rdata;
  tmc_mode_t    o_mode;
  logic         o_ovf_ch2;
  logic         o_irq;
  logic [7:0]   rd_val;
  int           n_errors = 0;
  int           checks = 0;
  int           cyc = 0;

  tmc_mode_ctrl i_dut (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_bus     (i_bus),
    .i_cnt2_evt(i_cnt2_evt),
    .o_rdata   (o_rdata),
    .o_mode    (o_mode),
    .o_ovf_ch2 (o_ovf_ch2),
    .o_irq     (o_irq)
  );

  // 50 MHz system clock
  always #10 i_clk_sys = ~i_clk_sys;

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs about 120 cycles
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    i_bus.wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    i_bus.rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic pulse(input logic o, input logic u);
    @(posedge i_clk_sys);
    i_cnt2_evt <= '{ovf: o, udf: u};
    @(posedge i_clk_sys);
    i_cnt2_evt <= '0;
    tick(1);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    tick(1);
    chk(o_irq, 8'h00);
    rd(TMC_OFS_MODE_SEL);
    chk(rd_val, TMC_RST_MODE_SEL);
    $display("reset test done");
    for (int ch = 0; ch < 5; ch++) begin
      wr(TMC_OFS_MODE_SEL, 8'h01 << ch);
      tick(1);
      chk(o_mode.pwm_mode, 8'h01 << ch);
      rd(TMC_OFS_MODE_SEL);
      chk(rd_val, 8'h80 | (8'h01 << ch));
    end
    wr(TMC_OFS_MODE_SEL, 8'h40);
    tick(1);
    chk(o_mode.ch2_phase_count, 8'h01);
    chk(o_mode.pwm_mode, 8'h00);
    chk(o_mode.ch2_ovf_on_udf, 8'h01);
    wr(TMC_OFS_MODE_SEL, 8'h20);
    tick(1);
    chk(o_mode.ch2_phase_count, 8'h00);
    chk(o_mode.ch2_ovf_on_udf, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(TMC_OFS_COMBO_SEL, 8'(c << 4));
      tick(1);
      chk(o_mode.pair_mode, c < 2 ? 8'h00 : c == 2 ? 8'h01 : 8'h02);
    end
    wr(TMC_OFS_SYNC_SEL, 8'h10);
    tick(1);
    chk(o_mode.sync_sel, 8'h10);
    wr(TMC_OFS_SYNC_SEL, 8'h00);
    tick(1);
    chk(o_mode.sync_sel, 8'h00);
    $display("mode test done");
    // underflow sets the overflow flag only while direction bit is clear
    wr(TMC_OFS_MODE_SEL, 8'h00);
    wr(TMC_OFS_IRQ_MASK, 8'h01);
    pulse(1'b0, 1'b1);
    chk(o_ovf_ch2, 8'h01);
    chk(o_irq, 8'h01);
    rd(TMC_OFS_IRQ_STAT);
    chk(rd_val, 8'h03);
    tick(2);
    chk({o_irq, o_ovf_ch2}, 8'h00);
    wr(TMC_OFS_MODE_SEL, 8'h20);
    pulse(1'b0, 1'b1);
    chk({o_irq, o_ovf_ch2}, 8'h00);
    rd(TMC_OFS_IRQ_STAT);
    chk(rd_val, 8'h02);
    pulse(1'b1, 1'b0);
    chk({o_irq, o_ovf_ch2}, 8'h03);
    wr(TMC_OFS_IRQ_MASK, 8'h00);
    tick(2);
    chk({o_irq, o_ovf_ch2}, 8'h01);
    wr(TMC_OFS_IRQ_STAT, 8'hFF);
    rd(TMC_OFS_IRQ_STAT);
    chk(rd_val, 8'h01);
    rd(TMC_OFS_IRQ_STAT);
    chk(rd_val, 8'h00);
    rd(8'h7F);
    chk(rd_val, 8'h00);
    $display("event test done");
    // reset in mid-run brings every control back to its reset value
    wr(TMC_OFS_MODE_SEL, 8'h5F);
    wr(TMC_OFS_COMBO_SEL, 8'h30);
    tick(2);
    chk(o_mode.pwm_mode, 8'h1F);
    chk(o_mode.pair_mode, TMC_PAIR_RESET_SYNC);
    i_rst_n <= 1'b0;
    tick(1);
    chk(o_mode.pwm_mode, 8'h00);
    chk(o_mode.pair_mode, TMC_PAIR_INDEPENDENT);
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    tick(1);
    chk(o_mode.ch2_ovf_on_udf, 8'h01);
    rd(TMC_OFS_MODE_SEL);
    chk(rd_val, TMC_RST_MODE_SEL);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule // tmc_mode_ctrl_tb_top
